// *** design/fsc_pkg.sv ***
// Purpose: Shared constants for the flash status and configuration bit block
// Assumes: Wishbone classic slave, 32-bit data, byte addresses
// Notes: Offsets are word aligned
package fsc_pkg;
  // Register byte offsets
  localparam logic [7:0] FSC_OFS_STATUS = 8'h00;
  localparam logic [7:0] FSC_OFS_CONFIG = 8'h04;
  localparam logic [7:0] FSC_OFS_CMD = 8'h08;
  localparam logic [7:0] FSC_OFS_TARGET = 8'h0C;
  localparam logic [7:0] FSC_OFS_WDATA = 8'h10;
  localparam logic [7:0] FSC_OFS_READ = 8'h14;
  // Status field positions
  localparam int FSC_BUSY_BIT = 0;
  localparam int FSC_WRLATCH_BIT = 1;
  localparam int FSC_BP_LSB = 2;
  localparam int FSC_BP_MSB = 4;
  localparam int FSC_SUSP_BIT = 5;
  localparam int FSC_CMDOK_BIT = 6;
  // Config field positions
  localparam int FSC_RSV_BIT = 7;
  localparam int FSC_WRAPLEN_LSB = 5;
  localparam int FSC_WRAPDIS_BIT = 4;
  localparam int FSC_LAT_LSB = 0;
  // Reset values
  localparam logic [7:0] FSC_CONFIG_RST = 8'h70;
  localparam logic [2:0] FSC_BP_RST = 3'h0;
  // Timing count in clk cycles, address width in bits
  localparam int FSC_OP_CYCLES = 16;
  localparam int FSC_ADDR_W = 22;
  // Command codes written to the command register
  typedef enum logic [3:0] {
    FSC_CMD_WREN = 4'h1,
    FSC_CMD_WRDI = 4'h2,
    FSC_CMD_PROG = 4'h3,
    FSC_CMD_SECT_ERASE = 4'h4,
    FSC_CMD_BLK_ERASE = 4'h5,
    FSC_CMD_CHIP_ERASE = 4'h6,
    FSC_CMD_WRSR = 4'h7,
    FSC_CMD_SEC_ERASE = 4'h8,
    FSC_CMD_SEC_PROG = 4'h9,
    FSC_CMD_VWREN = 4'hA,
    FSC_CMD_SUSPEND = 4'hB,
    FSC_CMD_RESUME = 4'hC,
    FSC_CMD_RDSR = 4'hD
  } fsc_cmd_type;
endpackage : fsc_pkg

// *** design/fsc_status_config.sv ***
// Purpose: Status and read configuration bits of a serial flash core
// Assumes: Wishbone classic slave, one clock, synchronous reset is power-up
// Notes: Embedded operations are timed by a fixed cycle count
//
// Summary of operation
// - Config bit 7 reserved, reads zero
// - Wrap length selects 8/16/32/64 byte window
// - Latency field sets fast/multi-IO read latency
// - Latency 1..15 cycles, zero disables variable
// - Busy set during program, erase, status write
// - Busy ignores all but status read, suspend
// - Busy clears when operation completes
// - Write enable sets write enable latch
// - Latch cleared at reset and write commands
// - Latch cleared even when protection blocks
// - Suspend clears write enable latch
// - Resume sets write enable latch again
// - Block protect bits 4:2, status write only
// - Block protect shields none, part, all
// - Block protect resets to zero
// - Command touching protected region is ignored
// - Operation starts only with latch set
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module fsc_status_config #(
  parameter int OP_CYCLES = fsc_pkg::FSC_OP_CYCLES,
  parameter int ADDR_W = fsc_pkg::FSC_ADDR_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Read path settings to the array logic
  output logic [3:0] read_latency_o,
  output logic var_latency_en_o,
  output logic [ADDR_W-1:0] read_addr_o
);
  import fsc_pkg::*;

  typedef enum logic [2:0] {
    FSC_ST_IDLE = 3'b001,
    FSC_ST_BUSY = 3'b010,
    FSC_ST_SUSP = 3'b100
  } fsc_state_type;

  localparam int CNT_W = $clog2(OP_CYCLES + 1);

  fsc_state_type state_r;
  logic write_enable_latch_r;
  logic [2:0] bp_r;
  logic [7:0] config_r;
  logic cmd_ok_r;
  logic vwren_r;
  logic [CNT_W-1:0] cnt_r;
  logic [ADDR_W-1:0] target_r;
  logic [7:0] wdata_r;
  logic [7:0] read_idx_r;
  logic pend_wrsr_r;
  logic [7:0] pend_data_r;
  logic pend_vol_r;
  logic pend_sr_r;
  logic [31:0] wb_dat_r;
  logic ack_r;
  logic [ADDR_W-1:0] read_addr_nxt;

  // Top-of-array region protected for a block protect code, 64 kB blocks
  function automatic logic is_protected(input logic [2:0] bp, input logic [ADDR_W-1:0] adr,
                                        input logic chip);
    logic [ADDR_W-1:0] lim;
    lim = '0;
    if (bp == 3'h0) begin
      is_protected = 1'b0;
    end else if (bp == 3'h7 || chip) begin
      is_protected = 1'b1;
    end else begin
      // Protected portion is the upper 1/2^(7-bp) of the array
      lim = ~(({ADDR_W{1'b1}}) >> (3'h7 - bp));
      is_protected = (adr >= lim);
    end
  endfunction : is_protected

  // Register select, shared by the read, write and command decoders
  function automatic logic reg_sel(input logic [7:0] adr, input logic [7:0] ofs);
    reg_sel = (adr == ofs);
  endfunction : reg_sel

  function automatic logic is_write_cmd(input logic [3:0] c);
    is_write_cmd = (c == FSC_CMD_PROG) || (c == FSC_CMD_SECT_ERASE) || (c == FSC_CMD_BLK_ERASE) ||
                   (c == FSC_CMD_CHIP_ERASE) || (c == FSC_CMD_WRSR) || (c == FSC_CMD_SEC_ERASE) ||
                   (c == FSC_CMD_SEC_PROG);
  endfunction : is_write_cmd

  function automatic logic is_array_cmd(input logic [3:0] c);
    is_array_cmd = (c == FSC_CMD_PROG) || (c == FSC_CMD_SECT_ERASE) || (c == FSC_CMD_BLK_ERASE) ||
                   (c == FSC_CMD_CHIP_ERASE);
  endfunction : is_array_cmd

  logic req;
  logic wr_stb;
  logic rd_stb;
  logic cmd_stb;
  logic [3:0] cmd_code;
  logic cmd_blocked;
  logic cmd_prot;
  logic [7:0] status_byte;

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_stb = req && wb_we_i && wb_sel_i[0];
  assign rd_stb = req && !wb_we_i;
  assign cmd_stb = wr_stb && reg_sel(wb_adr_i, FSC_OFS_CMD);
  // Status byte as software sees it
  assign status_byte = {1'b0, cmd_ok_r, state_r == FSC_ST_SUSP, bp_r, write_enable_latch_r,
                        state_r == FSC_ST_BUSY};
  assign cmd_code = wb_dat_i[3:0];
  // Only status read and suspend get through while busy
  assign cmd_blocked = (state_r == FSC_ST_BUSY) && (cmd_code != FSC_CMD_SUSPEND) &&
                       (cmd_code != FSC_CMD_RDSR);
  assign cmd_prot = is_array_cmd(cmd_code) &&
                    is_protected(bp_r, target_r, cmd_code == FSC_CMD_CHIP_ERASE);

  // Bus answer: registered ack one cycle after the request, ack drops the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_r <= 32'h0000_0000;
    end else if (rd_stb) begin
      if (reg_sel(wb_adr_i, FSC_OFS_STATUS)) begin
        wb_dat_r <= {24'h0, status_byte};
      end else if (reg_sel(wb_adr_i, FSC_OFS_CONFIG)) begin
        wb_dat_r <= {24'h0, 1'b0, config_r[6:0]};
      end else if (reg_sel(wb_adr_i, FSC_OFS_TARGET)) begin
        wb_dat_r <= 32'(target_r);
      end else if (reg_sel(wb_adr_i, FSC_OFS_WDATA)) begin
        wb_dat_r <= {24'h0, wdata_r};
      end else if (reg_sel(wb_adr_i, FSC_OFS_READ)) begin
        wb_dat_r <= {24'h0, read_idx_r};
      end else begin
        wb_dat_r <= 32'h0000_0000;
      end
    end
  end

  // Operand registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target_r <= '0;
      wdata_r <= 8'h00;
      read_idx_r <= 8'h00;
    end else if (wr_stb) begin
      if (reg_sel(wb_adr_i, FSC_OFS_TARGET)) begin
        target_r <= wb_dat_i[ADDR_W-1:0];
      end else if (reg_sel(wb_adr_i, FSC_OFS_WDATA)) begin
        wdata_r <= wb_dat_i[7:0];
      end else if (reg_sel(wb_adr_i, FSC_OFS_READ)) begin
        read_idx_r <= wb_dat_i[7:0];
      end
    end
  end

  // Last command accepted or refused, for software to check
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_ok_r <= 1'b1;
    end else if (cmd_stb) begin
      cmd_ok_r <= !cmd_blocked && !(is_write_cmd(cmd_code) && (!write_enable_latch_r || cmd_prot));
    end
  end

  // Operation sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= FSC_ST_IDLE;
      cnt_r <= '0;
      pend_wrsr_r <= 1'b0;
      pend_data_r <= 8'h00;
      pend_vol_r <= 1'b0;
      pend_sr_r <= 1'b0;
    end else begin
      pend_wrsr_r <= 1'b0;
      case (state_r)
        FSC_ST_IDLE: begin
          if (cmd_stb && is_write_cmd(cmd_code) && write_enable_latch_r && !cmd_prot) begin
            state_r <= FSC_ST_BUSY;
            cnt_r <= CNT_W'(OP_CYCLES);
            pend_data_r <= wdata_r;
            pend_vol_r <= (cmd_code == FSC_CMD_WRSR) && vwren_r;
            pend_sr_r <= (cmd_code == FSC_CMD_WRSR);
            pend_wrsr_r <= 1'b0;
          end
        end
        FSC_ST_BUSY: begin
          // Suspend freezes the count, so resume carries on from there
          if (cmd_stb && cmd_code == FSC_CMD_SUSPEND) begin
            state_r <= FSC_ST_SUSP;
          end else if (cnt_r <= CNT_W'(1)) begin
            state_r <= FSC_ST_IDLE;
            // Program and erase must never touch the protect or config bits
            pend_wrsr_r <= pend_sr_r;
          end else begin
            cnt_r <= cnt_r - CNT_W'(1);
          end
        end
        FSC_ST_SUSP: begin
          if (cmd_stb && cmd_code == FSC_CMD_RESUME) begin
            state_r <= FSC_ST_BUSY;
          end
        end
        default: begin
          state_r <= FSC_ST_IDLE;
        end
      endcase
    end
  end

  // Write enable latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      write_enable_latch_r <= 1'b0;
    end else if (cmd_stb && !cmd_blocked) begin
      if (cmd_code == FSC_CMD_WREN) begin
        write_enable_latch_r <= 1'b1;
      end else if (cmd_code == FSC_CMD_WRDI || is_write_cmd(cmd_code)) begin
        write_enable_latch_r <= 1'b0;
      end else if (cmd_code == FSC_CMD_SUSPEND && state_r == FSC_ST_BUSY) begin
        write_enable_latch_r <= 1'b0;
      end else if (cmd_code == FSC_CMD_RESUME && state_r == FSC_ST_SUSP) begin
        write_enable_latch_r <= 1'b1;
      end
    end
  end

  // Volatile write enable qualifies a status write only when it is the very next command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vwren_r <= 1'b0;
    end else if (cmd_stb && !cmd_blocked) begin
      vwren_r <= (cmd_code == FSC_CMD_VWREN);
    end
  end

  // Status write lands when the operation completes
  // Limitation: rst_i stands for factory state, so it clears protection too
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bp_r <= FSC_BP_RST;
    end else if (pend_wrsr_r && !pend_vol_r) begin
      bp_r <= pend_data_r[FSC_BP_MSB:FSC_BP_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_r <= FSC_CONFIG_RST;
    end else if (pend_wrsr_r && pend_vol_r) begin
      config_r <= {1'b0, pend_data_r[6:0]};
    end
  end

  fsc_wrap_addr #(
    .ADDR_W(ADDR_W)
  ) u_wrap (
    .start_i(target_r),
    .index_i(read_idx_r),
    .wrap_len_i(config_r[FSC_WRAPLEN_LSB+1:FSC_WRAPLEN_LSB]),
    .wrap_dis_i(config_r[FSC_WRAPDIS_BIT]),
    .addr_o(read_addr_nxt)
  );

  // Read path outputs registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_latency_o <= 4'h0;
      var_latency_en_o <= 1'b0;
      read_addr_o <= '0;
    end else begin
      read_latency_o <= config_r[FSC_LAT_LSB+3:FSC_LAT_LSB];
      var_latency_en_o <= (config_r[FSC_LAT_LSB+3:FSC_LAT_LSB] != 4'h0);
      read_addr_o <= read_addr_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = wb_dat_r;
endmodule : fsc_status_config
`default_nettype wire

// *** design/fsc_wrap_addr.sv ***
// Purpose: Wrapped burst address generator for reads
// Assumes: Start and index are byte addresses
// Notes: Pure combinational
`timescale 1ns/1ns
`default_nettype none
module fsc_wrap_addr #(
  parameter int ADDR_W = 22
) (
  // Inputs
  input wire logic [ADDR_W-1:0] start_i,
  input wire logic [7:0] index_i,
  input wire logic [1:0] wrap_len_i,
  input wire logic wrap_dis_i,
  // Output
  output logic [ADDR_W-1:0] addr_o
);
  logic [ADDR_W-1:0] lin;
  logic [ADDR_W-1:0] mask;
  always_comb begin
    lin = start_i + ADDR_W'(index_i);
    // 8 << len gives 8, 16, 32 or 64 byte windows
    mask = ADDR_W'((8'h08 << wrap_len_i) - 8'h01);
    if (wrap_dis_i) begin
      addr_o = lin;
    end else begin
      addr_o = (start_i & ~mask) | (lin & mask);
    end
  end
endmodule : fsc_wrap_addr
`default_nettype wire

// *** tb/fsc_host_model.sv ***
// Purpose: Host controller issuing commands
// Assumes: Wishbone classic master
// Notes: Waits are cut by the bench timeout
`timescale 1ns/1ns
`default_nettype none
module fsc_host_model (
  // Clock
  input wire logic clk_i,
  // Answer
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  // Request
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  import fsc_pkg::*;
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'hF;
    dat_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1) @(posedge clk_i);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd
  // Nothing else is sent until busy reads clear
  task automatic poll();
    logic [31:0] q;
    do rd(FSC_OFS_STATUS, q); while (q[FSC_BUSY_BIT] !== 1'b0);
  endtask : poll
endmodule : fsc_host_model
`default_nettype wire

// *** tb/fsc_props.sv ***
// Purpose: Bus and read path checks
// Assumes: One clock, sync reset
// Notes: Sees top ports only
`timescale 1ns/1ns
`default_nettype none
module fsc_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Read path
  input wire logic [3:0] read_latency_o,
  input wire logic var_latency_en_o
);
  import fsc_pkg::*;
  logic rd_ack;
  assign rd_ack = wb_ack_o && !wb_we_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_rsv_zero: assert property (rd_ack && wb_adr_i == FSC_OFS_CONFIG |-> wb_dat_o[31:7] == '0)
    else $error("config upper bits set");
  chk_lat_enable: assert property (var_latency_en_o == (read_latency_o != 4'h0))
    else $error("latency enable wrong");
  chk_lat_track: assert property (rd_ack && wb_adr_i == FSC_OFS_CONFIG |-> read_latency_o == wb_dat_o[3:0])
    else $error("latency output differs");
  chk_unmap_zero: assert property (rd_ack && wb_adr_i > FSC_OFS_READ |-> wb_dat_o == '0)
    else $error("unmapped read not zero");
  chk_dat_hold: assert property ($changed(wb_dat_o) |-> rd_ack)
    else $error("read data moved");
  cover property (rd_ack && wb_adr_i == FSC_OFS_STATUS && wb_dat_o[FSC_BUSY_BIT]);
  cover property (rd_ack && wb_adr_i == FSC_OFS_STATUS && wb_dat_o[FSC_SUSP_BIT]);
  cover property (var_latency_en_o);
endmodule : fsc_props
bind fsc_status_config fsc_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .read_latency_o(read_latency_o), .var_latency_en_o(var_latency_en_o));
`default_nettype wire

// *** tb/test_flash_status_config_bits.sv ***
// Purpose: Command and register sequences
// Assumes: Operation count of 40 cycles, longer than the default 16
// Notes: Expected values from the bit map
`timescale 1ns/1ns
`default_nettype none
module test_flash_status_config_bits;
  import fsc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack, var_en;
  logic [7:0] adr;
  logic [3:0] sel, lat;
  logic [31:0] wdat, rdat, q, cv;
  logic [FSC_ADDR_W-1:0] raddr;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int w;
  always #50 clk_i = ~clk_i;
  fsc_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  fsc_status_config #(.OP_CYCLES(40), .ADDR_W(FSC_ADDR_W)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .read_latency_o(lat), .var_latency_en_o(var_en),
    .read_addr_o(raddr));
  task automatic final_report();
    if (fails == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      final_report();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cmd(input logic [3:0] c);
    host.wr(FSC_OFS_CMD, {28'h0, c});
  endtask : cmd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, q);
    check(q, e);
  endtask : rd_chk
  // Volatile enable must directly precede the write
  task automatic set_cfg(input logic [31:0] v);
    host.wr(FSC_OFS_WDATA, v);
    cmd(FSC_CMD_WREN);
    cmd(FSC_CMD_VWREN);
    cmd(FSC_CMD_WRSR);
    host.poll();
  endtask : set_cfg
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(FSC_OFS_STATUS, 32'h40);
    rd_chk(FSC_OFS_CONFIG, 32'h70);
    rd_chk(8'h20, 32'h0);
    cmd(FSC_CMD_PROG);
    rd_chk(FSC_OFS_STATUS, 32'h00);
    cmd(FSC_CMD_WREN);
    rd_chk(FSC_OFS_STATUS, 32'h42);
    cmd(FSC_CMD_WRDI);
    rd_chk(FSC_OFS_STATUS, 32'h40);
    host.wr(FSC_OFS_WDATA, 32'h1C);
    cmd(FSC_CMD_WREN);
    cmd(FSC_CMD_WRSR);
    rd_chk(FSC_OFS_STATUS, 32'h41);
    host.poll();
    rd_chk(FSC_OFS_STATUS, 32'h5C);
    for (int c = 3; c < 7; c++) begin
      cmd(FSC_CMD_WREN);
      cmd(4'(c));
      rd_chk(FSC_OFS_STATUS, 32'h1C);
    end
    host.wr(FSC_OFS_WDATA, 32'h0);
    cmd(FSC_CMD_WREN);
    cmd(FSC_CMD_WRSR);
    host.poll();
    cmd(FSC_CMD_WREN);
    cmd(FSC_CMD_PROG);
    cmd(FSC_CMD_WREN);
    rd_chk(FSC_OFS_STATUS, 32'h01);
    cmd(FSC_CMD_RDSR);
    rd_chk(FSC_OFS_STATUS, 32'h41);
    cmd(FSC_CMD_SUSPEND);
    rd_chk(FSC_OFS_STATUS, 32'h60);
    cmd(FSC_CMD_RESUME);
    rd_chk(FSC_OFS_STATUS, 32'h43);
    host.poll();
    host.wr(FSC_OFS_WDATA, 32'h1C);
    for (int c = 8; c < 10; c++) begin
      cmd(FSC_CMD_WREN);
      cmd(4'(c));
      rd_chk(FSC_OFS_STATUS, 32'h41);
      host.poll();
      rd_chk(FSC_OFS_STATUS, 32'h40);
    end
    set_cfg(32'h8B);
    rd_chk(FSC_OFS_CONFIG, 32'h0B);
    check({28'h0, lat}, 32'hB);
    check({31'h0, var_en}, 32'h1);
    host.wr(FSC_OFS_TARGET, 32'h13D);
    host.wr(FSC_OFS_READ, 32'h0A);
    for (int i = 0; i < 5; i++) begin
      cv = (i < 4) ? 32'(i << 5) : 32'h70;
      set_cfg(cv);
      repeat (2) @(posedge clk_i);
      w = 8 << i;
      check(32'(raddr), (i < 4) ? ((32'h13D & ~(w - 1)) | (32'h147 & (w - 1))) : 32'h147);
    end
    check({31'h0, var_en}, 32'h0);
    set_cfg(32'h2B);
    cmd(FSC_CMD_WREN);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(FSC_OFS_STATUS, 32'h40);
    rd_chk(FSC_OFS_CONFIG, 32'h70);
    check({28'h0, lat}, 32'h0);
    final_report();
  end
endmodule : test_flash_status_config_bits
`default_nettype wire
